// >>> rtl/aqs_pkg.sv
/*
  Shared constants for the acquisition sequencer: timing, widths, states.
  Assumes a single 25 MHz core clock and active-low asynchronous reset.
*/
`default_nettype none
package aqs_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CORE_CLK_HZ       = 25_000_000;
   localparam int PACE_PERIOD_NS    = 4000;       // Default internal pace period
   localparam int PACE_DIV_CYCLES   = (PACE_PERIOD_NS * (CORE_CLK_HZ / 1_000_000)) / 1000;
   // ==========================================================
   // Sizes
   localparam int CHAN_W            = 5;          // Channel number width
   localparam int RANGE_W           = 2;          // Input range code width
   localparam int SAMPLE_W          = 16;         // Converter word width
   localparam int SCAN_DEPTH        = 8;          // Scan list entries
   localparam int SCAN_IDX_W        = 3;
   localparam int FIFO_DEPTH        = 16;         // Onboard FIFO words
   localparam int FIFO_IDX_W        = 4;
   localparam int COUNT_W           = 24;         // Finite sample counter
   // ==========================================================
   // Sequencer states, Gray along idle-load-convert-wait path
   typedef enum logic [1:0] {
      AQS_IDLE    = 2'b00,
      AQS_LOAD    = 2'b01,
      AQS_CONVERT = 2'b11,
      AQS_WAIT    = 2'b10
   } aqs_state_t;
endpackage
`default_nettype wire

// >>> rtl/aqs_sample_fifo.sv
/*
  Sample FIFO in flip-flops. When full and not read in the same cycle, a
  write overwrites the oldest word and raises a one-cycle overwrite pulse.
  Assumes writer and reader on the same clock.
*/
`default_nettype none
module aqs_sample_fifo #(
   parameter int WIDTH = aqs_pkg::SAMPLE_W,
   parameter int DEPTH = aqs_pkg::FIFO_DEPTH,
   parameter int IDX_W = aqs_pkg::FIFO_IDX_W
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // Write side
   input  wire logic             wrValid,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  overwrite,
   // Read side
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic [WIDTH-1:0]      rdData
);
   // ==========================================================
   // Storage and pointers
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [IDX_W-1:0] wrPtr_reg, wrPtr_next;
   logic [IDX_W-1:0] rdPtr_reg, rdPtr_next;
   logic [IDX_W:0]   fill_reg, fill_next;
   logic             ovw_reg, ovw_next;
   logic             full, doRead;

   assign full      = (fill_reg == (IDX_W+1)'(DEPTH));
   assign doRead    = rdReady && (fill_reg != '0);
   assign rdValid   = (fill_reg != '0);
   assign rdData    = mem_reg[rdPtr_reg];
   assign overwrite = ovw_reg;

   // ==========================================================
   // Pointer arithmetic; full write with no read drops the oldest word
   always_comb begin
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      fill_next  = fill_reg;
      ovw_next   = 1'b0;
      if (flush) begin
         wrPtr_next = '0;
         rdPtr_next = '0;
         fill_next  = '0;
      end else begin
         if (wrValid) begin
            wrPtr_next = wrPtr_reg + 1'b1;
         end
         if (wrValid && full && !doRead) begin
            rdPtr_next = rdPtr_reg + 1'b1;   // RULE9
            ovw_next   = 1'b1;               // RULE10
         end else if (doRead) begin
            rdPtr_next = rdPtr_reg + 1'b1;
            if (!wrValid) fill_next = fill_reg - 1'b1;
         end else if (wrValid) begin
            fill_next = fill_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         fill_reg  <= '0;
         ovw_reg   <= 1'b0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         fill_reg  <= fill_next;
         ovw_reg   <= ovw_next;
      end
   end

   // Data store has no reset; valid tracking covers it
   always_ff @(posedge core_clk) begin
      if (wrValid && !flush) mem_reg[wrPtr_reg] <= wrData;
   end
endmodule
`default_nettype wire

// >>> rtl/aqs_sequencer.sv
/*
  Analog-input acquisition sequencer: scan list stepping, gain loading,
  software or hardware pacing, finite/continuous modes, FIFO and error.
  Assumes a converter with start/done handshake on core_clk; external
  pace clock and trigger arrive asynchronously on pins.
*/
`default_nettype none
// Overview of operation
// [RULE1] Load gain range before converting new channel
// [RULE2] One conversion per software command
// [RULE3] Hardware pacing from internal or external clock
// [RULE4] Hardware trigger only in hardware-timed mode
// [RULE5] Hardware-timed samples go through the FIFO
// [RULE6] Finite mode stops after preset count
// [RULE7] Host uses finite mode with reference trigger; the sequencer has no reference trigger, only a start trigger on startTrigPin
// [RULE8] Continuous runs until host stop
// [RULE9] Full FIFO overwrites oldest unread data
// [RULE10] Raise error on FIFO overwrite
// [RULE11] Ignore pace pulses while not acquiring
// [RULE12] Sample counter loads count, decrements per pulse
// [RULE13] Error stays until cleared or new start
module aqs_sequencer #(
   parameter int PACE_DIV = aqs_pkg::PACE_DIV_CYCLES
) (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   // Host control
   input  wire logic                          hwTimed,
   input  wire logic                          finiteMode,
   input  wire logic                          extPaceSel,
   input  wire logic                          trigEnable,
   input  wire logic                          startCmd,
   input  wire logic                          stopCmd,
   input  wire logic                          swConvCmd,
   input  wire logic                          errClear,
   input  wire logic [aqs_pkg::COUNT_W-1:0]   sampleCount,
   input  wire logic [aqs_pkg::SCAN_IDX_W-1:0] scanLen,
   // Scan list write port
   input  wire logic                          scanWr,
   input  wire logic [aqs_pkg::SCAN_IDX_W-1:0] scanWrIdx,
   input  wire logic [aqs_pkg::CHAN_W-1:0]    scanWrChan,
   input  wire logic [aqs_pkg::RANGE_W-1:0]   scanWrRange,
   // Pins
   input  wire logic                          acquisition_pace_clock,
   input  wire logic                          startTrigPin,
   // Mux and gain amplifier
   output logic [aqs_pkg::CHAN_W-1:0]         muxChan,
   output logic [aqs_pkg::RANGE_W-1:0]        programmable_gain_amp,
   output logic                               gainLoad,
   // Converter
   output logic                               convStart,
   input  wire logic                          convDone,
   input  wire logic [aqs_pkg::SAMPLE_W-1:0]  convData,
   // Software single-sample result
   output logic [aqs_pkg::SAMPLE_W-1:0]       swData,
   output logic                               swValid,
   // Stream toward USB
   output logic                               streamValid,
   input  wire logic                          streamReady,
   output logic [aqs_pkg::SAMPLE_W-1:0]       streamData,
   // Status
   output logic                               running,
   output logic                               overflowErr
);
   // ==========================================================
   // Scan list storage
   logic [aqs_pkg::CHAN_W-1:0]  scanChan_reg  [aqs_pkg::SCAN_DEPTH];
   logic [aqs_pkg::RANGE_W-1:0] scanRange_reg [aqs_pkg::SCAN_DEPTH];

   genvar gi;
   generate
      for (gi = 0; gi < aqs_pkg::SCAN_DEPTH; gi++) begin : gScan
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               scanChan_reg[gi]  <= '0;
               scanRange_reg[gi] <= '0;
            end else if (scanWr && scanWrIdx == gi) begin
               scanChan_reg[gi]  <= scanWrChan;
               scanRange_reg[gi] <= scanWrRange;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Pin synchronisers and edge detect (third stage for edge only)
   logic [2:0] paceSync_reg;
   logic [2:0] trigSync_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         paceSync_reg <= '0;
         trigSync_reg <= '0;
      end else begin
         paceSync_reg <= {paceSync_reg[1:0], acquisition_pace_clock};
         trigSync_reg <= {trigSync_reg[1:0], startTrigPin};
      end
   end
   logic extPaceEdge, trigEdge;
   assign extPaceEdge = paceSync_reg[1] && !paceSync_reg[2];
   assign trigEdge    = trigSync_reg[1] && !trigSync_reg[2];

   // ==========================================================
   // Internal pace divider; runs only while acquiring
   logic [31:0] divCnt_reg, divCnt_next;
   logic        intPace;
   logic        armed_reg, armed_next;   // Waiting for start trigger
   logic        run_reg, run_next;
   assign intPace = run_reg && (divCnt_reg == 32'(PACE_DIV - 1));
   always_comb begin
      divCnt_next = '0;
      if (run_reg && !intPace) divCnt_next = divCnt_reg + 32'h1;
   end

   // Selected pace pulse, masked outside an acquisition
   logic pacePulse;
   assign pacePulse = run_reg && (extPaceSel ? extPaceEdge : intPace); // RULE3 RULE11

   // ==========================================================
   // Sequencer control
   aqs_pkg::aqs_state_t state_reg, state_next;
   logic [aqs_pkg::SCAN_IDX_W-1:0] idx_reg, idx_next;
   logic [aqs_pkg::COUNT_W-1:0]    cnt_reg, cnt_next;
   logic                           swMode_reg, swMode_next;
   logic [aqs_pkg::CHAN_W-1:0]     mux_reg, mux_next;
   logic [aqs_pkg::RANGE_W-1:0]    gain_reg, gain_next;
   logic                           gLoad_reg, gLoad_next;
   logic                           cStart_reg, cStart_next;
   logic [aqs_pkg::SAMPLE_W-1:0]   swData_reg, swData_next;
   logic                           swValid_reg, swValid_next;
   logic                           err_reg, err_next;
   logic                           fifoWr, fifoOvw, fifoFlush;
   logic                           scanLast;

   assign scanLast = (idx_reg == scanLen);

   always_comb begin
      state_next   = state_reg;
      idx_next     = idx_reg;
      cnt_next     = cnt_reg;
      swMode_next  = swMode_reg;
      mux_next     = mux_reg;
      gain_next    = gain_reg;
      gLoad_next   = 1'b0;
      cStart_next  = 1'b0;
      swData_next  = swData_reg;
      swValid_next = 1'b0;
      run_next     = run_reg;
      armed_next   = armed_reg;
      fifoWr       = 1'b0;
      fifoFlush    = 1'b0;
      // Start of a hardware-timed acquisition
      if (startCmd && hwTimed && !run_reg) begin
         fifoFlush = 1'b1;
         cnt_next  = sampleCount;                         // RULE12
         idx_next  = '0;
         if (trigEnable) armed_next = 1'b1;              // RULE4
         else run_next = 1'b1;
      end
      if (armed_reg && trigEdge && hwTimed) begin        // RULE4
         armed_next = 1'b0;
         run_next   = 1'b1;
      end
      // Host stop ends any acquisition
      if (stopCmd) begin                                 // RULE8
         run_next   = 1'b0;
         armed_next = 1'b0;
      end
      case (state_reg)
         aqs_pkg::AQS_IDLE: begin
            if (pacePulse && (!finiteMode || cnt_reg != '0)) begin
               swMode_next = 1'b0;
               idx_next    = '0;
               state_next  = aqs_pkg::AQS_LOAD;
               if (finiteMode) cnt_next = cnt_reg - 1'b1; // RULE12
            end else if (swConvCmd && !hwTimed && !run_reg) begin // RULE2
               swMode_next = 1'b1;
               state_next  = aqs_pkg::AQS_LOAD;
            end
         end
         aqs_pkg::AQS_LOAD: begin
            // Gain set with channel, one cycle ahead of the start
            mux_next   = scanChan_reg[idx_reg];
            gain_next  = scanRange_reg[idx_reg];         // RULE1
            gLoad_next = 1'b1;                           // RULE1
            state_next = aqs_pkg::AQS_CONVERT;
         end
         aqs_pkg::AQS_CONVERT: begin
            cStart_next = 1'b1;                          // RULE2
            state_next  = aqs_pkg::AQS_WAIT;
         end
         aqs_pkg::AQS_WAIT: begin
            if (convDone) begin
               if (swMode_reg) begin
                  swData_next  = convData;
                  swValid_next = 1'b1;
                  state_next   = aqs_pkg::AQS_IDLE;
               end else begin
                  fifoWr = 1'b1;                         // RULE5
                  if (scanLast) begin
                     state_next = aqs_pkg::AQS_IDLE;
                     if (finiteMode && cnt_reg == '0) run_next = 1'b0; // RULE6
                  end else begin
                     idx_next   = idx_reg + 1'b1;
                     state_next = aqs_pkg::AQS_LOAD;
                  end
               end
            end
         end
         default: state_next = aqs_pkg::AQS_IDLE;
      endcase
      // Overwrite sets; set beats clear, new start clears
      err_next = err_reg;
      if (errClear || fifoFlush) err_next = 1'b0;        // RULE13
      if (fifoOvw) err_next = 1'b1;                      // RULE10
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= aqs_pkg::AQS_IDLE;
         idx_reg     <= '0;
         cnt_reg     <= '0;
         swMode_reg  <= 1'b0;
         mux_reg     <= '0;
         gain_reg    <= '0;
         gLoad_reg   <= 1'b0;
         cStart_reg  <= 1'b0;
         swData_reg  <= '0;
         swValid_reg <= 1'b0;
         run_reg     <= 1'b0;
         armed_reg   <= 1'b0;
         err_reg     <= 1'b0;
         divCnt_reg  <= '0;
      end else begin
         state_reg   <= state_next;
         idx_reg     <= idx_next;
         cnt_reg     <= cnt_next;
         swMode_reg  <= swMode_next;
         mux_reg     <= mux_next;
         gain_reg    <= gain_next;
         gLoad_reg   <= gLoad_next;
         cStart_reg  <= cStart_next;
         swData_reg  <= swData_next;
         swValid_reg <= swValid_next;
         run_reg     <= run_next;
         armed_reg   <= armed_next;
         err_reg     <= err_next;
         divCnt_reg  <= divCnt_next;
      end
   end

   // ==========================================================
   // Sample FIFO toward the host stream
   logic                         fValid;
   logic [aqs_pkg::SAMPLE_W-1:0] fData;
   logic                         streamValid_reg;   // Output word waiting for the host
   logic [aqs_pkg::SAMPLE_W-1:0] streamData_reg;    // Held until the handshake
   aqs_sample_fifo u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .flush     (fifoFlush),
      .wrValid   (fifoWr),
      .wrData    (convData),
      .overwrite (fifoOvw),
      .rdValid   (fValid),
      .rdReady   (streamReady && !streamValid_reg),
      .rdData    (fData)
   );

   // Output stage so stream outputs come from flip-flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         streamValid_reg <= 1'b0;
         streamData_reg  <= '0;
      end else if (streamValid_reg) begin
         if (streamReady) streamValid_reg <= 1'b0;
      end else if (streamReady && fValid) begin
         streamValid_reg <= 1'b1;
         streamData_reg  <= fData;
      end
   end

   assign muxChan               = mux_reg;
   assign programmable_gain_amp = gain_reg;
   assign gainLoad              = gLoad_reg;
   assign convStart             = cStart_reg;
   assign swData                = swData_reg;
   assign swValid               = swValid_reg;
   assign streamValid           = streamValid_reg;
   assign streamData            = streamData_reg;
   assign running               = run_reg;
   assign overflowErr           = err_reg;
endmodule
`default_nettype wire

// >>> testbench/aqs_seq_chk.sv
/*
  Port checker for the acquisition sequencer.
  Assumes it is bound to aqs_sequencer and sees only its ports.
*/
`default_nettype none
module aqs_seq_chk (
   // Clock, reset and control
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        hwTimed,
   input wire logic        finiteMode,
   input wire logic        startCmd,
   input wire logic        stopCmd,
   input wire logic        swConvCmd,
   input wire logic        errClear,
   // Outputs watched
   input wire logic        gainLoad,
   input wire logic        convStart,
   input wire logic        convDone,
   input wire logic        swValid,
   input wire logic        streamValid,
   input wire logic        streamReady,
   input wire logic [15:0] streamData,
   input wire logic        running,
   input wire logic        overflowErr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Gain before conversion, software result only after converter done
   a_gain_then_conv: assert property (gainLoad |=> convStart)
      else $error("convStart did not follow gainLoad");
   a_conv_after_gain: assert property (convStart |-> $past(gainLoad))
      else $error("convStart without gainLoad before it");
   a_sw_result_cause: assert property (swValid |-> $past(convDone))
      else $error("swValid without convDone");
   // Pulses while idle must start nothing
   a_idle_no_scan: assert property (gainLoad |-> running || $past(swConvCmd, 2))
      else $error("gainLoad while idle");
   a_run_hw_only: assert property ($rose(running) |-> $past(hwTimed))
      else $error("acquisition started in software timing");
   a_stop_ends: assert property (stopCmd && running && !finiteMode |=> !running)
      else $error("running after stop");
   // Stream hold and spacing
   a_stream_hold: assert property (streamValid && !streamReady |=>
      streamValid && $stable(streamData))
      else $error("stream word dropped or changed");
   a_stream_gap: assert property (streamValid && streamReady |=> !streamValid)
      else $error("stream words closer than two cycles");
   // Sticky overflow error
   a_err_sticky: assert property (overflowErr && !errClear && !startCmd |=> overflowErr)
      else $error("overflowErr dropped without clear");
   a_err_cause: assert property ($rose(overflowErr) |->
      $past(convDone) || $past(convDone, 2) || $past(convDone, 3))
      else $error("overflowErr rose without a write");
   c_sw_done: cover property (swValid);
   c_overflow: cover property ($rose(overflowErr));
   c_finite_end: cover property ($fell(running) && finiteMode);
   c_stream: cover property (streamValid && streamReady);
endmodule
bind aqs_sequencer aqs_seq_chk chk_u (.core_clk, .rst_n, .hwTimed, .finiteMode, .startCmd,
   .stopCmd, .swConvCmd, .errClear, .gainLoad, .convStart, .convDone, .swValid, .streamValid,
   .streamReady, .streamData, .running, .overflowErr);
`default_nettype wire

// >>> testbench/aqs_host_model.sv
/*
  Host reader on the sample stream: drains words with periodic stalls.
  Assumes hold from the bench stalls it fully.
*/
`default_nettype none
module aqs_host_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Stream
   input wire logic hold,
   input wire logic streamValid,
   output logic     streamReady
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt;   // Stall pattern counter
   // Ready moves only on the falling edge, two stalls in eight cycles
   always @(negedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 3'h0;
         streamReady <= 1'b0;
      end else begin
         cnt <= cnt + 3'h1;
         streamReady <= !hold && (cnt[2:1] != 2'h3);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
  Self-checking bench for aqs_sequencer with a converter model and
  a host reader. Assumes a 25 MHz core clock and PACE_DIV of 4.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_n, hwTimed, finiteMode, extPaceSel, trigEnable;
   logic startCmd, stopCmd, swConvCmd, errClear, scanWr, hold;
   logic acquisition_pace_clock, startTrigPin, gainLoad, convStart, convDone;
   logic swValid, streamValid, streamReady, running, overflowErr;
   logic [23:0] sampleCount;
   logic [2:0]  scanLen, scanWrIdx;
   logic [4:0]  scanWrChan, muxChan, chanTab [8];
   logic [1:0]  scanWrRange, programmable_gain_amp, rngTab [8];
   logic [15:0] convData, swData, streamData, lastData, pushed [$], got [$];
   logic [31:0] rnd;
   int          n_mismatch, tests_run, nConv, cd, expIdx, n0;
   // ==========================================================
   // Design, host reader
   aqs_sequencer #(.PACE_DIV(4)) dut_u (.core_clk, .rst_n, .hwTimed, .finiteMode,
      .extPaceSel, .trigEnable, .startCmd, .stopCmd, .swConvCmd, .errClear, .sampleCount,
      .scanLen, .scanWr, .scanWrIdx, .scanWrChan, .scanWrRange, .acquisition_pace_clock,
      .startTrigPin, .muxChan, .programmable_gain_amp, .gainLoad, .convStart, .convDone,
      .convData, .swData, .swValid, .streamValid, .streamReady, .streamData, .running,
      .overflowErr);
   aqs_host_model host_u (.core_clk, .rst_n, .hold, .streamValid, .streamReady);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   // Bounded wait for a level, then compare it
   task automatic waitFor(ref logic s, input logic v, input int lim);
      int k;
      k = 0;
      while (s !== v && k < lim) begin
         cyc(1);
         k++;
      end
      chk("wait level", {15'h0, v}, {15'h0, s});
   endtask
   // Streamed words against the newest depth words written
   task automatic cmpList(input int depth);
      int b;
      b = (pushed.size() > depth) ? pushed.size() - depth : 0;
      chk("word count", 16'(pushed.size() - b), 16'(got.size()));
      foreach (got[i]) chk("stream word", pushed[b + i], got[i]);
      pushed.delete();
      got.delete();
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // Monitor: channel and range at each conversion, stream capture
   always @(posedge core_clk) begin
      if (convStart === 1'b1) begin
         nConv++;
         cd = 2;
         chk("muxChan", 16'(chanTab[expIdx]), 16'(muxChan));
         chk("gain range", 16'(rngTab[expIdx]), 16'(programmable_gain_amp));
         if (hwTimed) expIdx = (expIdx == scanLen) ? 0 : expIdx + 1;
      end
      if (streamValid === 1'b1 && streamReady === 1'b1) got.push_back(streamData);
   end
   // Converter model: answers two falling edges after a start
   always @(negedge core_clk) begin
      convDone <= (cd == 1);
      if (cd == 1) begin
         convData <= rnd[15:0];
         lastData = rnd[15:0];
         if (hwTimed) pushed.push_back(rnd[15:0]);
         rnd = lfsr(rnd);
      end
      if (cd > 0) cd--;
   end
   initial begin
      #200000;
      n_mismatch++;
      $display("ERROR watchdog expected done seen timeout");
      report_and_stop();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, hwTimed, finiteMode, extPaceSel, trigEnable, startCmd, stopCmd} = 7'h0;
      {swConvCmd, errClear, scanWr, acquisition_pace_clock, startTrigPin} = 5'h0;
      {sampleCount, scanLen, scanWrIdx, scanWrChan, scanWrRange, convData} = 53'h0;
      {convDone, cd, expIdx, nConv} = '0;
      hold = 1'b1;
      rnd = 32'h51553CA6;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) rst_n = 1'b1;
      cyc(2);
      for (int i = 0; i < 8; i++) begin
         chanTab[i] = rnd[4:0];
         rngTab[i] = rnd[9:8];
         rnd = lfsr(rnd);
         scanWrIdx = i[2:0];
         scanWrChan = chanTab[i];
         scanWrRange = rngTab[i];
         pulse(scanWr);
      end
      // Software conversions, a second command while busy is refused
      repeat (3) begin
         n0 = nConv;
         pulse(swConvCmd);
         pulse(swConvCmd);
         waitFor(swValid, 1'b1, 30);
         chk("swData", lastData, swData);
         cyc(4);
         chk("sw conversions", 16'h1, 16'(nConv - n0));
      end
      // Finite internal pacing, three scans of three entries
      {hold, hwTimed, finiteMode, scanLen, sampleCount} = {3'b011, 3'h2, 24'h3};
      n0 = nConv;
      pulse(startCmd);
      waitFor(running, 1'b0, 500);
      chk("finite conversions", 16'h9, 16'(nConv - n0));
      cyc(80);
      cmpList(16);
      // External pace pulses while idle
      extPaceSel = 1'b1;
      n0 = nConv;
      repeat (3) begin
         acquisition_pace_clock = 1'b1;
         cyc(4);
         acquisition_pace_clock = 1'b0;
         cyc(4);
      end
      chk("idle conversions", 16'h0, 16'(nConv - n0));
      // Continuous external pacing with the host stalled
      {hold, finiteMode, scanLen} = {2'b10, 3'h7};
      expIdx = 0;
      pulse(startCmd);
      repeat (3) begin
         acquisition_pace_clock = 1'b1;
         cyc(4);
         acquisition_pace_clock = 1'b0;
         cyc(60);
      end
      chk("ext conversions", 16'd24, 16'(nConv - n0));
      chk("overflowErr set", 16'h1, 16'(overflowErr));
      pulse(stopCmd);
      chk("running after stop", 16'h0, 16'(running));
      hold = 1'b0;
      cyc(100);
      cmpList(16);
      chk("overflowErr held", 16'h1, 16'(overflowErr));
      pulse(errClear);
      chk("overflowErr cleared", 16'h0, 16'(overflowErr));
      // Start trigger gates a finite hardware start
      {trigEnable, finiteMode, extPaceSel, scanLen, sampleCount} = {3'b110, 3'h0, 24'h2};
      expIdx = 0;
      pulse(startCmd);
      cyc(20);
      chk("running before trigger", 16'h0, 16'(running));
      startTrigPin = 1'b1;
      cyc(5);
      chk("running after trigger", 16'h1, 16'(running));
      waitFor(running, 1'b0, 200);
      startTrigPin = 1'b0;
      cyc(30);
      cmpList(16);
      report_and_stop();
   end
endmodule
`default_nettype wire
